// ==== sleep_ctrl_pkg.sv ====
// Constants and types for the sleep and external interrupt controller
package sleep_ctrl_pkg;
   localparam logic [7:0] CTRL_INDEX      = 8'h35;
   localparam logic [9:0] CTRL_ADDR       = 10'h0D4;
   localparam logic [7:0] STATUS_ADDR_IDX = 8'h36;
   localparam logic [9:0] STATUS_ADDR     = 10'h0D8;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] CTRL_WMASK      = 8'h7B;
   localparam int         PULLUP_KILL_BIT = 6;
   localparam int         SLEEP_ARM_BIT   = 5;
   localparam int         SEL_HI_BIT      = 4;
   localparam int         SEL_LO_BIT      = 3;
   localparam int         SENSE_HI_BIT    = 1;
   localparam int         SENSE_LO_BIT    = 0;
   localparam logic [1:0] SEL_IDLE        = 2'h0;
   localparam logic [1:0] SEL_ADC_NR      = 2'h1;
   localparam logic [1:0] SEL_PDOWN       = 2'h2;
   localparam logic [1:0] SEL_STANDBY     = 2'h3;
   localparam logic [1:0] SENSE_LOW       = 2'h0;
   localparam logic [1:0] SENSE_ANY       = 2'h1;
   localparam logic [1:0] SENSE_FALL      = 2'h2;
   localparam logic [1:0] SENSE_RISE      = 2'h3;
   localparam int         STANDBY_WAKE_CYC = 6;
   localparam int         HALT_EXTRA_CYC   = 4;
   localparam int         STARTUP_DEF_CYC  = 64;
   localparam logic [15:0] CNT_ONE         = 16'h0001;

   typedef enum logic [2:0] {
      ST_RUN, ST_SLEEP, ST_STARTUP, ST_HALT
   } sleep_state_e;

   typedef struct packed {
      logic core;
      logic flash;
      logic io;
      logic adc;
      logic osc;
   } clk_gate_s;

   typedef struct packed {
      logic adc_done;
      logic mem_ready;
      logic serial_start;
      logic pin_change;
      logic other_io;
   } wake_src_s;
endpackage

// ==== sleep_ctrl.sv ====
// Sleep controller with general control register and external interrupt 0 sensing
// Function
// - Bits 7 and 2 of the control register read zero and ignore writes.
// - Pull-up kill bit set disables all port pull-ups regardless of pin setup.
// - Sleep instruction enters sleep only when the sleep arm bit is one.
// - Sleep select: 00 idle, 01 ADC noise reduction, 10 power-down, 11 standby.
// - Sense field: 00 low level, 01 any change, 10 falling, 11 rising edge.
// - External interrupt 0 fires only with global flag and its mask bit set.
// - Idle stops only core and flash clocks; I/O and ADC clocks run.
// - Idle wakes on any enabled interrupt, external or internal.
// - Entering idle or ADC noise reduction with ADC on starts a conversion.
// - ADC noise reduction stops I/O, core and flash clocks; ADC clock runs.
// - ADC noise reduction wakes on ADC, memory-ready, serial start, level, pin change.
// - Power-down stops the oscillator and all generated clocks.
// - Power-down wakes on serial start, level interrupt 0 or pin change.
// - Power-down wake waits the fuse-selected start-up period before resuming.
// - Vanished level or pin-change wake cause wakes without running its handler.
// - Standby is power-down with oscillator running; wakes within six cycles.
// - Memory-ready and ADC wake only idle and noise reduction; other I/O only idle.
// - After interrupt wake, core halts four extra cycles, then runs the handler.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module sleep_ctrl
   import sleep_ctrl_pkg::*;
#(
   parameter int STARTUP_CYC = STARTUP_DEF_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        sleep_instr_i,
   input  wire logic        global_irq_en_i,
   input  wire logic        ext_irq_mask_i,
   input  wire logic        ext_irq_pin_i,
   input  wire logic        adc_enabled_i,
   input  wire logic        irq_other_i,
   input  wire wake_src_s   wake_i,
   output logic             pullup_kill_o,
   output clk_gate_s        clk_run_o,
   output logic             adc_start_o,
   output logic             ext_irq_req_o,
   output logic             core_resume_o,
   output logic             sleeping_o
);
   logic [7:0]   ctrl;
   logic         pin_q;
   logic         edge_hit;
   logic         lvl_hit;
   logic         irq0_cond;
   logic         wake_now;
   logic         lvl_wake;
   sleep_state_e state;
   logic [15:0]  cnt;
   logic [15:0]  wait_cyc;
   logic [1:0]   mode;
   logic         bus_req;
   logic [7:0]   rd_byte;

   function automatic logic wake_ok(input logic [1:0] m, input wake_src_s w,
                                    input logic lvl, input logic oth);
      logic r;
      r = w.serial_start | w.pin_change | lvl;
      if (m == SEL_IDLE || m == SEL_ADC_NR) begin
         r = r | w.adc_done | w.mem_ready;
      end
      if (m == SEL_IDLE) begin
         r = r | w.other_io | oth;
      end
      return r;
   endfunction

   assign mode    = ctrl[SEL_HI_BIT:SEL_LO_BIT];
   assign bus_req = cyc_i & stb_i & ~ack_o;

   // Register write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
      end else if (bus_req && we_i && sel_i[0] && adr_i == CTRL_ADDR) begin
         ctrl <= dat_i[7:0] & CTRL_WMASK;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      if (adr_i == CTRL_ADDR) begin
         rd_byte = ctrl & CTRL_WMASK;
      end else if (adr_i == STATUS_ADDR) begin
         rd_byte = {5'h00, state == ST_STARTUP, state == ST_HALT, sleeping_o};
      end
   end

   // Bus answer, one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         dat_o <= (bus_req && !we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pullup_kill_o <= 1'b0;
      end else begin
         pullup_kill_o <= ctrl[PULLUP_KILL_BIT];
      end
   end

   // External interrupt 0 sensing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= ext_irq_pin_i;
      end
   end

   always_comb begin
      lvl_hit = ~ext_irq_pin_i;
      case (ctrl[SENSE_HI_BIT:SENSE_LO_BIT])
         SENSE_LOW:  edge_hit = lvl_hit;
         SENSE_ANY:  edge_hit = pin_q ^ ext_irq_pin_i;
         SENSE_FALL: edge_hit = pin_q & ~ext_irq_pin_i;
         SENSE_RISE: edge_hit = ~pin_q & ext_irq_pin_i;
         default:    edge_hit = 1'b0;
      endcase
   end

   assign lvl_wake  = (ctrl[SENSE_HI_BIT:SENSE_LO_BIT] == SENSE_LOW) & lvl_hit
                      & ext_irq_mask_i;
   assign irq0_cond = edge_hit & global_irq_en_i & ext_irq_mask_i;
   assign wake_now  = wake_ok(mode, wake_i, lvl_wake,
                              irq0_cond | (irq_other_i & global_irq_en_i));
   assign wait_cyc = (mode == SEL_PDOWN) ? 16'(STARTUP_CYC)
                   : (mode == SEL_STANDBY) ? 16'(STANDBY_WAKE_CYC) : CNT_ONE;

   // Sleep sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_RUN;
         cnt   <= 16'h0000;
      end else begin
         case (state)
            ST_RUN: begin
               if (sleep_instr_i && ctrl[SLEEP_ARM_BIT]) begin
                  state <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (wake_now) begin
                  state <= ST_STARTUP;
                  cnt   <= wait_cyc;
               end
            end
            ST_STARTUP: begin
               if (cnt <= CNT_ONE) begin
                  state <= ST_HALT;
                  cnt   <= 16'(HALT_EXTRA_CYC);
               end else begin
                  cnt <= cnt - CNT_ONE;
               end
            end
            ST_HALT: begin
               if (cnt <= CNT_ONE) begin
                  state <= ST_RUN;
               end else begin
                  cnt <= cnt - CNT_ONE;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // Clock gating and outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_run_o     <= '1;
         sleeping_o    <= 1'b0;
         adc_start_o   <= 1'b0;
         ext_irq_req_o <= 1'b0;
         core_resume_o <= 1'b0;
      end else begin
         sleeping_o  <= (state == ST_SLEEP);
         adc_start_o <= (state == ST_RUN) && sleep_instr_i && ctrl[SLEEP_ARM_BIT]
                        && adc_enabled_i && (mode == SEL_IDLE || mode == SEL_ADC_NR);
         clk_run_o <= '1;
         if (state == ST_SLEEP || state == ST_STARTUP) begin
            clk_run_o.core  <= 1'b0;
            clk_run_o.flash <= 1'b0;
            clk_run_o.io    <= (mode == SEL_IDLE);
            clk_run_o.adc   <= (mode == SEL_IDLE || mode == SEL_ADC_NR);
            clk_run_o.osc   <= (mode != SEL_PDOWN) || state == ST_STARTUP;
         end else if (state == ST_HALT) begin
            clk_run_o.core <= 1'b0;
         end
         core_resume_o <= (state == ST_HALT) && (cnt <= CNT_ONE);
         // Handler only if cause still present at resume
         ext_irq_req_o <= (state == ST_RUN) ? irq0_cond
                        : ((state == ST_HALT) && (cnt <= CNT_ONE) && irq0_cond);
      end
   end

   property p_reserved_zero;
      @(posedge clk_i) disable iff (rst_i)
         ack_o |-> (dat_o[7] == 1'b0 && dat_o[2] == 1'b0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_pullup;
      @(posedge clk_i) disable iff (rst_i)
         ctrl[PULLUP_KILL_BIT] |=> pullup_kill_o;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up kill not applied");

   property p_no_sleep_unarmed;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_RUN && sleep_instr_i && !ctrl[SLEEP_ARM_BIT]) |=> state == ST_RUN;
   endproperty
   a_no_sleep_unarmed: assert property (p_no_sleep_unarmed) else $error("slept unarmed");

   property p_idle_clocks;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_IDLE) |=> (!clk_run_o.core && clk_run_o.io);
   endproperty
   a_idle_clocks: assert property (p_idle_clocks) else $error("idle clock gating");

   property p_pdown_osc;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_PDOWN) |=> !clk_run_o.osc;
   endproperty
   a_pdown_osc: assert property (p_pdown_osc) else $error("oscillator on in power-down");

   property p_standby_wake;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_STANDBY && wake_now) |=> ##[1:6] state == ST_HALT;
   endproperty
   a_standby_wake: assert property (p_standby_wake) else $error("standby wake slow");

   property p_halt_four;
      @(posedge clk_i) disable iff (rst_i)
         $rose(state == ST_HALT) |-> (state == ST_HALT) [*4] ##1 state == ST_RUN;
   endproperty
   a_halt_four: assert property (p_halt_four) else $error("halt not four cycles");

   property p_other_io_idle_only;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode != SEL_IDLE && !wake_i.serial_start
          && !wake_i.pin_change && !lvl_wake && !wake_i.adc_done && !wake_i.mem_ready)
         |=> state == ST_SLEEP;
   endproperty
   a_other_io_idle_only: assert property (p_other_io_idle_only) else $error("bad wake");

   property p_reset_ctrl;
      @(posedge clk_i)
         rst_i |=> ctrl == CTRL_RESET;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared");

   property p_reset_outputs;
      @(posedge clk_i)
         rst_i |=> (clk_run_o == '1 && !sleeping_o && !pullup_kill_o);
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not reset");

   property p_reserved_store;
      @(posedge clk_i) disable iff (rst_i)
         1'b1 |-> (ctrl[7] == 1'b0 && ctrl[2] == 1'b0);
   endproperty
   a_reserved_store: assert property (p_reserved_store) else $error("reserved bit stored");

   property p_pullup_off;
      @(posedge clk_i) disable iff (rst_i)
         !ctrl[PULLUP_KILL_BIT] |=> !pullup_kill_o;
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-up kill stuck");

   property p_sleep_armed;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_RUN && sleep_instr_i && ctrl[SLEEP_ARM_BIT]) |=> state == ST_SLEEP;
   endproperty
   a_sleep_armed: assert property (p_sleep_armed) else $error("armed sleep not taken");

   property p_adc_nr_clocks;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_ADC_NR)
         |=> (!clk_run_o.io && clk_run_o.adc && !clk_run_o.core);
   endproperty
   a_adc_nr_clocks: assert property (p_adc_nr_clocks) else $error("noise clocks");

   property p_pdown_clocks;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_PDOWN)
         |=> (!clk_run_o.io && !clk_run_o.adc && !clk_run_o.core && !clk_run_o.flash);
   endproperty
   a_pdown_clocks: assert property (p_pdown_clocks) else $error("power-down clocks");

   property p_standby_osc;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_STANDBY) |=> (clk_run_o.osc && !clk_run_o.io);
   endproperty
   a_standby_osc: assert property (p_standby_osc) else $error("standby oscillator");

   property p_pdown_startup;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_PDOWN && wake_now)
         |=> (state == ST_STARTUP && cnt == 16'(STARTUP_CYC));
   endproperty
   a_pdown_startup: assert property (p_pdown_startup) else $error("start-up delay");

   property p_idle_wake;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_IDLE && wake_i.other_io) |=> state == ST_STARTUP;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");

   property p_nr_adc_wake;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_ADC_NR && wake_i.adc_done) |=> state == ST_STARTUP;
   endproperty
   a_nr_adc_wake: assert property (p_nr_adc_wake) else $error("noise mode no wake");

   property p_pdown_serial;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_SLEEP && mode == SEL_PDOWN && wake_i.serial_start)
         |=> state == ST_STARTUP;
   endproperty
   a_pdown_serial: assert property (p_pdown_serial) else $error("power-down no wake");

   property p_resume_pulse;
      @(posedge clk_i) disable iff (rst_i)
         core_resume_o |=> !core_resume_o;
   endproperty
   a_resume_pulse: assert property (p_resume_pulse) else $error("resume not a pulse");

   property p_irq_gated;
      @(posedge clk_i) disable iff (rst_i)
         (!global_irq_en_i || !ext_irq_mask_i) |=> !ext_irq_req_o;
   endproperty
   a_irq_gated: assert property (p_irq_gated) else $error("request while masked");

   property p_adc_start;
      @(posedge clk_i) disable iff (rst_i)
         (state == ST_RUN && sleep_instr_i && ctrl[SLEEP_ARM_BIT] && adc_enabled_i
          && mode == SEL_IDLE) |=> adc_start_o;
   endproperty
   a_adc_start: assert property (p_adc_start) else $error("no conversion start");
endmodule

// ==== core_model.sv ====
// Core-side model issuing sleep instructions and masking interrupt 0
`timescale 1ns/1ps
module core_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic go_i,
   input  wire logic mask_req_i,
   input  wire logic sense_busy_i,
   output logic      sleep_instr_o,
   output logic      ext_irq_mask_o
);
   logic go_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         go_q          <= 1'b0;
         sleep_instr_o <= 1'b0;
      end else begin
         go_q          <= go_i;
         sleep_instr_o <= go_i & ~go_q;
      end
   end
   // Mask dropped while the sense field changes
   assign ext_irq_mask_o = mask_req_i & ~sense_busy_i;
endmodule

// ==== test_sleep_mode_and_ext_irq_control.sv ====
// Bench for the sleep controller
`timescale 1ns/1ps
module test_sleep_mode_and_ext_irq_control;
   import sleep_ctrl_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, gie = 0, mreq = 0;
   logic        sbusy = 0, pin = 1, adce = 0, oth = 0, adc_seen = 0, req_seen = 0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wdat = 32'h0, dat_o;
   logic        ack_o, sleep_instr, mask, pullup_kill_o, adc_start_o, ext_irq_req_o;
   logic        core_resume_o, sleeping_o;
   logic [7:0]  q;
   wake_src_s   wk = '0;
   clk_gate_s   clk_run_o;
   int          err_total = 0, compares = 0;
   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (adc_start_o === 1'b1) adc_seen <= 1'b1;
      if (ext_irq_req_o === 1'b1) req_seen <= 1'b1;
   end
   core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .mask_req_i(mreq),
      .sense_busy_i(sbusy), .sleep_instr_o(sleep_instr), .ext_irq_mask_o(mask));
   sleep_ctrl #(.STARTUP_CYC(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .sleep_instr_i(sleep_instr), .global_irq_en_i(gie), .ext_irq_mask_i(mask),
      .ext_irq_pin_i(pin), .adc_enabled_i(adce), .irq_other_i(oth), .wake_i(wk),
      .pullup_kill_o(pullup_kill_o), .clk_run_o(clk_run_o), .adc_start_o(adc_start_o),
      .ext_irq_req_o(ext_irq_req_o), .core_resume_o(core_resume_o), .sleeping_o(sleeping_o));
   task automatic end_sim();
      if (err_total == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic sense(input logic [1:0] m);
      sbusy <= 1'b1;
      wb(1'b1, CTRL_ADDR, {6'h0, m});
      sbusy <= 1'b0;
      tick(3);
      req_seen = 1'b0;
   endtask
   task automatic nap(input logic [1:0] m, input logic [4:0] run, input int lo, input logic as);
      int n;
      n = 0;
      wb(1'b1, CTRL_ADDR, {2'h0, 1'b1, m, 3'h0});
      adc_seen = 1'b0;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(4);
      chk(sleeping_o, 8'h01);
      chk(clk_run_o, run);
      chk(adc_seen, as);
      if (m != SEL_IDLE) begin
         oth          <= 1'b1;
         wk.other_io  <= 1'b1;
         wk.mem_ready <= (m != SEL_ADC_NR);
         wk.adc_done  <= (m != SEL_ADC_NR);
         tick(12);
         chk(sleeping_o, 8'h01);
         oth <= 1'b0;
         wk  <= '0;
         tick(1);
      end
      case (m)
         SEL_IDLE: wk.other_io <= 1'b1;
         SEL_ADC_NR: wk.adc_done <= 1'b1;
         default: wk.serial_start <= 1'b1;
      endcase
      while (core_resume_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk(n >= lo && n <= lo + 3, 8'h01);
      oth <= 1'b0;
      wk  <= '0;
      tick(3);
   endtask
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
   initial begin
      tick(20);
      rst_i <= 1'b0;
      wb(1'b0, CTRL_ADDR, 8'h00);
      chk(q, CTRL_RESET);
      chk(pullup_kill_o, 8'h00);
      wb(1'b1, CTRL_ADDR, 8'hFF);
      wb(1'b0, CTRL_ADDR, 8'h00);
      chk(q, 8'h7B);
      chk(pullup_kill_o, 8'h01);
      wb(1'b1, CTRL_ADDR, 8'h00);
      wb(1'b1, 10'h100, 8'hFF);
      wb(1'b0, 10'h100, 8'h00);
      chk(q, 8'h00);
      wb(1'b0, CTRL_ADDR, 8'h00);
      chk(q, 8'h00);
      tick(1);
      chk(pullup_kill_o, 8'h00);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(5);
      chk(sleeping_o, 8'h00);
      adce <= 1'b1;
      nap(SEL_IDLE, 5'h07, 5, 1'b1);
      nap(SEL_ADC_NR, 5'h03, 5, 1'b1);
      adce <= 1'b0;
      nap(SEL_PDOWN, 5'h00, 12, 1'b0);
      nap(SEL_STANDBY, 5'h01, 10, 1'b0);
      gie  <= 1'b1;
      mreq <= 1'b1;
      sense(SENSE_LOW);
      pin <= 1'b0;
      tick(4);
      chk(ext_irq_req_o, 8'h01);
      gie <= 1'b0;
      tick(4);
      chk(ext_irq_req_o, 8'h00);
      gie <= 1'b1;
      pin <= 1'b1;
      tick(4);
      chk(ext_irq_req_o, 8'h00);
      for (int m = 3; m > 0; m--) begin
         sense(m[1:0]);
         pin <= 1'b0;
         tick(5);
         chk(req_seen, m != 3);
         req_seen = 1'b0;
         pin <= 1'b1;
         tick(5);
         chk(req_seen, m != 2);
      end
      end_sim();
   end
endmodule
